// File: tlc_pkg.sv
// Shared constants for the transceiver reconfiguration and loopback controller.
// Assumes a single 50 MHz management clock; all counts derive from it here.
package tlc_pkg;
   // Register port geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;

   // Register indices on the plain register port
   localparam logic [3:0] REG_CH_SEL     = 4'h0;
   localparam logic [3:0] REG_LOOPBACK   = 4'h1;
   localparam logic [3:0] REG_DIFF_SWING = 4'h2;
   localparam logic [3:0] REG_PREEMPH    = 4'h3;
   localparam logic [3:0] REG_RX_EQ      = 4'h4;
   localparam logic [3:0] REG_DC_GAIN    = 4'h5;
   localparam logic [3:0] REG_CLK_DIV    = 4'h6;
   localparam logic [3:0] REG_PLL_SEL    = 4'h7;
   localparam logic [3:0] REG_STATUS     = 4'h8;

   // Field widths of the per-channel loopback, analog and clock settings
   localparam int LB_W      = 2;
   localparam int SWING_W   = 6;
   localparam int PREEMPH_W = 5;
   localparam int EQ_W      = 3;
   localparam int GAIN_W    = 2;
   localparam int DIV_W     = 2;
   localparam int FACTOR_W  = 4;

   // Loopback mode codes; code 3 is treated as off
   localparam logic [1:0] LB_OFF  = 2'h0;
   localparam logic [1:0] LB_PRE  = 2'h1;
   localparam logic [1:0] LB_POST = 2'h2;

   // Reset values of the per-channel settings
   localparam logic [5:0] SWING_RST   = 6'h10;
   localparam logic [4:0] PREEMPH_RST = 5'h00;
   localparam logic [2:0] EQ_RST      = 3'h0;
   localparam logic [1:0] GAIN_RST    = 2'h0;
   localparam logic [1:0] DIV_RST     = 2'h0;

   // Status register bit positions
   localparam int STAT_BUSY_BIT    = 0;
   localparam int STAT_CAL_BIT     = 1;
   localparam int STAT_REFUSED_BIT = 2;

   // Timing: an analog update takes at least OP_TIME_NS, a channel
   // calibration at least CAL_TIME_NS; least times round up
   localparam int CLK_PERIOD_NS = 20;
   localparam int OP_TIME_NS    = 200;
   localparam int CAL_TIME_NS   = 10000;
   localparam int OP_CYCLES     = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CAL_CYCLES    = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Controller states
   typedef enum logic [1:0] {
      ST_CAL,
      ST_IDLE,
      ST_OP
   } tlc_state_t;

   // Divider code 0..3 to one-hot divide factor 1, 2, 4, 8
   function automatic logic [FACTOR_W-1:0] div_factor(input logic [DIV_W-1:0] code);
      div_factor = 4'h1 << code;
   endfunction

   // Illegal loopback code falls back to off
   function automatic logic [LB_W-1:0] lb_legal(input logic [LB_W-1:0] code);
      lb_legal = (code == LB_PRE || code == LB_POST) ? code : LB_OFF;
   endfunction
endpackage

// File: tlc_offset_cal.sv
// One channel's offset cancellation engine: runs a fixed-length calibration.
// Assumes start_i is a one-cycle pulse from the controller's sequencer and
// that its reset is the power-up reset, not the controller reset.
`timescale 1ns/100ps
`default_nettype none
module tlc_offset_cal #(
   parameter int CAL_CYCLES = tlc_pkg::CAL_CYCLES
) (
   input  wire logic clk_i,
   input  wire logic por_rst_i,
   input  wire logic start_i,
   output logic      active_o,
   output logic      done_o
);
   localparam int CNT_W = $clog2(CAL_CYCLES + 1);

   logic [CNT_W-1:0] cnt_reg;

   generate
      if (CAL_CYCLES < 1) begin : g_bad
         $error("tlc_offset_cal: CAL_CYCLES must be at least one");
      end
   endgenerate

   // Calibration counter; done stays up until the next power-up
   always_ff @(posedge clk_i or posedge por_rst_i) begin
      if (por_rst_i) begin
         cnt_reg  <= '0;
         active_o <= 1'b0;
         done_o   <= 1'b0;
      end else if (start_i && !active_o && !done_o) begin
         cnt_reg  <= CNT_W'(CAL_CYCLES - 1);
         active_o <= 1'b1;
      end else if (active_o) begin
         if (cnt_reg == '0) begin
            active_o <= 1'b0;
            done_o   <= 1'b1;
         end else begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end

   // Done only ever follows a running engine
   AST_CAL_ENDS: assert property (@(posedge clk_i) disable iff (por_rst_i)
      $rose(done_o) |-> $past(active_o) && !active_o)
      else $error("calibration done without a running engine");
endmodule
`default_nettype wire

// File: tlc_reconfig_ctrl.sv
// Reconfiguration controller: register port, offset cancellation sequencing,
// busy signalling, per-channel analog, loopback and clock settings.
// Assumes one management clock; por_rst_i comes only at power-up, rst_i may
// be pulsed in user mode; the master keeps to the plain register protocol.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module tlc_reconfig_ctrl #(
   parameter int NUM_CH     = 4,
   parameter int NUM_PLL    = 2,
   parameter int OP_CYCLES  = tlc_pkg::OP_CYCLES,
   parameter int CAL_CYCLES = tlc_pkg::CAL_CYCLES
) (
   input  wire logic                                      clk_i,
   input  wire logic                                      rst_i,
   input  wire logic                                      por_rst_i,
   input  wire logic [tlc_pkg::ADDR_W-1:0]                addr_i,
   input  wire logic [tlc_pkg::DATA_W-1:0]                wdata_i,
   input  wire logic                                      wr_i,
   input  wire logic                                      rd_i,
   output logic      [tlc_pkg::DATA_W-1:0]                rdata_o,
   output logic                                           busy_o,
   output logic      [NUM_CH-1:0]                         lb_pre_o,
   output logic      [NUM_CH-1:0]                         lb_post_o,
   output logic      [NUM_CH-1:0]                         cdr_bypass_o,
   output logic      [NUM_CH-1:0]                         tx_stages_en_o,
   output logic      [NUM_CH-1:0]                         post_tap_only_o,
   output logic      [NUM_CH-1:0]                         rx_fabric_en_o,
   output logic      [NUM_CH-1:0][tlc_pkg::SWING_W-1:0]   diff_swing_o,
   output logic      [NUM_CH-1:0][tlc_pkg::PREEMPH_W-1:0] preemph_o,
   output logic      [NUM_CH-1:0][tlc_pkg::EQ_W-1:0]      rx_eq_o,
   output logic      [NUM_CH-1:0][tlc_pkg::GAIN_W-1:0]    dc_gain_o,
   output logic      [NUM_CH-1:0][tlc_pkg::FACTOR_W-1:0]  clk_div_o,
   output logic      [NUM_CH-1:0][$clog2(NUM_PLL)-1:0]    pll_sel_o
);
   localparam int CH_W  = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
   localparam int PLL_W = $clog2(NUM_PLL);
   localparam int OP_W  = 8;

   tlc_pkg::tlc_state_t state_reg;
   tlc_pkg::tlc_state_t state_next;

   logic [CH_W-1:0]           ch_sel_reg;
   logic [CH_W-1:0]           op_ch_reg;
   logic [3:0]                op_field_reg;
   logic [tlc_pkg::DATA_W-1:0] op_data_reg;
   logic [OP_W-1:0]           op_cnt_reg;
   logic                      refused_reg;
   logic [NUM_CH-1:0][tlc_pkg::LB_W-1:0]  lb_mode_reg;
   logic [NUM_CH-1:0][tlc_pkg::DIV_W-1:0] div_code_reg;
   logic [CH_W-1:0]           cal_idx_reg;
   logic                      cal_start_reg;
   logic                      cal_launched_reg;
   logic                      cal_done_reg;
   logic [NUM_CH-1:0]         unit_done;
   logic                      field_wr;
   logic                      accept;
   logic                      refuse;
   logic                      op_apply;

   generate
      if (NUM_CH < 1 || NUM_CH > 16) begin : g_bad_ch
         $error("tlc_reconfig_ctrl: NUM_CH must be 1..16");
      end
      if (NUM_PLL < 2 || NUM_PLL > 8) begin : g_bad_pll
         $error("tlc_reconfig_ctrl: NUM_PLL must be 2..8");
      end
      if (OP_CYCLES < 1 || OP_CYCLES > 255) begin : g_bad_op
         $error("tlc_reconfig_ctrl: OP_CYCLES must be 1..255");
      end
   endgenerate

   // One calibration engine per channel, started one after another
   genvar gc;
   generate
      for (gc = 0; gc < NUM_CH; gc++) begin : g_cal
         tlc_offset_cal #(
            .CAL_CYCLES (CAL_CYCLES)
         ) u_cal (
            .clk_i     (clk_i),
            .por_rst_i (por_rst_i),
            .start_i   (cal_start_reg && (cal_idx_reg == CH_W'(gc))),
            .active_o  (),
            .done_o    (unit_done[gc])
         );
      end
   endgenerate

   // Calibration sequencer on power-up reset only, so a controller
   // reset in user mode leaves the finished calibration alone
   always_ff @(posedge clk_i or posedge por_rst_i) begin
      if (por_rst_i) begin
         cal_idx_reg      <= '0;
         cal_start_reg    <= 1'b0;
         cal_launched_reg <= 1'b0;
         cal_done_reg     <= 1'b0;
      end else begin
         cal_start_reg <= 1'b0;
         if (!cal_done_reg) begin
            if (!cal_launched_reg) begin
               cal_start_reg    <= 1'b1;
               cal_launched_reg <= 1'b1;
            end else if (unit_done[cal_idx_reg]) begin
               if (cal_idx_reg == CH_W'(NUM_CH - 1)) begin
                  cal_done_reg <= 1'b1;
               end else begin
                  cal_idx_reg      <= cal_idx_reg + 1'b1;
                  cal_launched_reg <= 1'b0;
               end
            end
         end
      end
   end

   // Write classification; only field writes start an operation
   assign field_wr = wr_i && (addr_i >= tlc_pkg::REG_LOOPBACK) &&
                     (addr_i <= tlc_pkg::REG_PLL_SEL);
   // Pre-emphasis is frozen on a channel in pre-recovery loopback
   assign refuse   = field_wr && ((state_reg != tlc_pkg::ST_IDLE) ||
                     (addr_i == tlc_pkg::REG_PREEMPH &&
                      lb_mode_reg[ch_sel_reg] == tlc_pkg::LB_PRE));
   assign accept   = field_wr && !refuse;
   assign op_apply = (state_reg == tlc_pkg::ST_OP) && (op_cnt_reg == '0);

   // Next state: no operation is accepted before calibration ends
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         tlc_pkg::ST_CAL: begin
            if (cal_done_reg) begin
               state_next = tlc_pkg::ST_IDLE;
            end
         end
         tlc_pkg::ST_IDLE: begin
            if (accept) begin
               state_next = tlc_pkg::ST_OP;
            end
         end
         tlc_pkg::ST_OP: begin
            if (op_apply) begin
               state_next = tlc_pkg::ST_IDLE;
            end
         end
         default: state_next = tlc_pkg::ST_CAL;
      endcase
   end

   // State and busy; busy is registered from the next state so it
   // rises in the same edge that takes the write
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= tlc_pkg::ST_CAL;
         busy_o    <= 1'b1;
      end else begin
         state_reg <= state_next;
         busy_o    <= (state_next != tlc_pkg::ST_IDLE);
      end
   end

   // Operation latch: channel, field and data captured at acceptance
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         op_ch_reg    <= '0;
         op_field_reg <= 4'h0;
         op_data_reg  <= '0;
         op_cnt_reg   <= '0;
      end else if (accept) begin
         op_ch_reg    <= ch_sel_reg;
         op_field_reg <= addr_i;
         op_data_reg  <= wdata_i;
         op_cnt_reg   <= OP_W'(OP_CYCLES - 1);
      end else if (state_reg == tlc_pkg::ST_OP && op_cnt_reg != '0) begin
         op_cnt_reg <= op_cnt_reg - 1'b1;
      end
   end

   // Channel select; out-of-range channels are refused
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ch_sel_reg <= '0;
      end else if (wr_i && addr_i == tlc_pkg::REG_CH_SEL && wdata_i < NUM_CH) begin
         ch_sel_reg <= wdata_i[CH_W-1:0];
      end
   end

   // Sticky refusal flag; a new refusal beats a write-one clear
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         refused_reg <= 1'b0;
      end else if (refuse || (wr_i && addr_i == tlc_pkg::REG_CH_SEL &&
                              wdata_i >= NUM_CH)) begin
         refused_reg <= 1'b1;
      end else if (wr_i && addr_i == tlc_pkg::REG_STATUS &&
                   wdata_i[tlc_pkg::STAT_REFUSED_BIT]) begin
         refused_reg <= 1'b0;
      end
   end

   // Loopback path controls; mode reaches the channel only by a
   // register operation, there is no pin for it
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         lb_mode_reg     <= '0;
         lb_pre_o        <= '0;
         lb_post_o       <= '0;
         cdr_bypass_o    <= '0;
         tx_stages_en_o  <= '1;
         post_tap_only_o <= '0;
         rx_fabric_en_o  <= '1;
      end else if (op_apply && op_field_reg == tlc_pkg::REG_LOOPBACK) begin
         lb_mode_reg[op_ch_reg]     <= tlc_pkg::lb_legal(op_data_reg[tlc_pkg::LB_W-1:0]);
         lb_pre_o[op_ch_reg]        <= tlc_pkg::lb_legal(op_data_reg[tlc_pkg::LB_W-1:0]) ==
                                       tlc_pkg::LB_PRE;
         // Unclocked buffer-to-driver path skips clock recovery
         cdr_bypass_o[op_ch_reg]    <= tlc_pkg::lb_legal(op_data_reg[tlc_pkg::LB_W-1:0]) ==
                                       tlc_pkg::LB_PRE;
         // Only the transmit buffer stays in a pre-recovery loop
         tx_stages_en_o[op_ch_reg]  <= tlc_pkg::lb_legal(op_data_reg[tlc_pkg::LB_W-1:0]) !=
                                       tlc_pkg::LB_PRE;
         lb_post_o[op_ch_reg]       <= tlc_pkg::lb_legal(op_data_reg[tlc_pkg::LB_W-1:0]) ==
                                       tlc_pkg::LB_POST;
         // Recovered clock makes first post-tap only, saves taps
         post_tap_only_o[op_ch_reg] <= tlc_pkg::lb_legal(op_data_reg[tlc_pkg::LB_W-1:0]) ==
                                       tlc_pkg::LB_POST;
         rx_fabric_en_o[op_ch_reg]  <= 1'b1;
      end
   end

   // Analog settings of the addressed channel
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         diff_swing_o <= {NUM_CH{tlc_pkg::SWING_RST}};
         preemph_o    <= {NUM_CH{tlc_pkg::PREEMPH_RST}};
         rx_eq_o      <= {NUM_CH{tlc_pkg::EQ_RST}};
         dc_gain_o    <= {NUM_CH{tlc_pkg::GAIN_RST}};
      end else if (op_apply) begin
         case (op_field_reg)
            tlc_pkg::REG_DIFF_SWING: diff_swing_o[op_ch_reg] <=
                                     op_data_reg[tlc_pkg::SWING_W-1:0];
            tlc_pkg::REG_PREEMPH:    preemph_o[op_ch_reg] <=
                                     op_data_reg[tlc_pkg::PREEMPH_W-1:0];
            tlc_pkg::REG_RX_EQ:      rx_eq_o[op_ch_reg] <= op_data_reg[tlc_pkg::EQ_W-1:0];
            tlc_pkg::REG_DC_GAIN:    dc_gain_o[op_ch_reg] <= op_data_reg[tlc_pkg::GAIN_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // Data-rate settings: local divider and transmit PLL choice
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_code_reg <= {NUM_CH{tlc_pkg::DIV_RST}};
         clk_div_o    <= {NUM_CH{tlc_pkg::div_factor(tlc_pkg::DIV_RST)}};
         pll_sel_o    <= '0;
      end else if (op_apply && op_field_reg == tlc_pkg::REG_CLK_DIV) begin
         div_code_reg[op_ch_reg] <= op_data_reg[tlc_pkg::DIV_W-1:0];
         clk_div_o[op_ch_reg]    <= tlc_pkg::div_factor(op_data_reg[tlc_pkg::DIV_W-1:0]);
      end else if (op_apply && op_field_reg == tlc_pkg::REG_PLL_SEL &&
                   op_data_reg < NUM_PLL) begin
         pll_sel_o[op_ch_reg] <= op_data_reg[PLL_W-1:0];
      end
   end

   // Read data stand for one cycle only; unmapped reads give zero
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         case (addr_i)
            tlc_pkg::REG_CH_SEL:     rdata_o <= tlc_pkg::DATA_W'(ch_sel_reg);
            tlc_pkg::REG_LOOPBACK:   rdata_o <= tlc_pkg::DATA_W'(lb_mode_reg[ch_sel_reg]);
            tlc_pkg::REG_DIFF_SWING: rdata_o <= tlc_pkg::DATA_W'(diff_swing_o[ch_sel_reg]);
            tlc_pkg::REG_PREEMPH:    rdata_o <= tlc_pkg::DATA_W'(preemph_o[ch_sel_reg]);
            tlc_pkg::REG_RX_EQ:      rdata_o <= tlc_pkg::DATA_W'(rx_eq_o[ch_sel_reg]);
            tlc_pkg::REG_DC_GAIN:    rdata_o <= tlc_pkg::DATA_W'(dc_gain_o[ch_sel_reg]);
            tlc_pkg::REG_CLK_DIV:    rdata_o <= tlc_pkg::DATA_W'(div_code_reg[ch_sel_reg]);
            tlc_pkg::REG_PLL_SEL:    rdata_o <= tlc_pkg::DATA_W'(pll_sel_o[ch_sel_reg]);
            tlc_pkg::REG_STATUS:     rdata_o <= tlc_pkg::DATA_W'({refused_reg, cal_done_reg,
                                                                  busy_o});
            default:                 rdata_o <= '0;
         endcase
      end else begin
         rdata_o <= '0;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || por_rst_i);

   AST_BUSY_DURING_OP: assert property (state_reg == tlc_pkg::ST_OP |-> busy_o)
      else $error("busy low during an operation");
   AST_BUSY_UNTIL_CAL: assert property (!cal_done_reg |=> busy_o)
      else $error("busy low before calibration finished");
   AST_BUSY_DROPS: assert property ($rose(cal_done_reg) && !wr_i |-> ##1 !busy_o)
      else $error("busy did not drop after calibration");
   AST_CAL_KEPT: assert property (cal_done_reg |=> cal_done_reg)
      else $error("calibration rerun or lost");
   AST_OP_BOUNDED: assert property ($rose(state_reg == tlc_pkg::ST_OP) |->
                                    ##[1:256] state_reg == tlc_pkg::ST_IDLE)
      else $error("operation did not finish");
   // Refusal shows in the cycle after the strobe; a clear may follow at once
   AST_BUSY_REFUSED: assert property (field_wr && busy_o |=>
                                      $stable(op_data_reg) && refused_reg)
      else $error("write taken while busy");

   // Path checks on every channel, not only the first one
   for (genvar ga = 0; ga < NUM_CH; ga++) begin : g_ast
      AST_PREEMPH_FROZEN: assert property (lb_mode_reg[ga] == tlc_pkg::LB_PRE &&
                                           $past(lb_mode_reg[ga]) == tlc_pkg::LB_PRE |->
                                           $stable(preemph_o[ga]))
         else $error("pre-emphasis changed in pre-recovery loopback");
      AST_PRE_PATH: assert property (lb_pre_o[ga] |->
                                     cdr_bypass_o[ga] && !tx_stages_en_o[ga] &&
                                     rx_fabric_en_o[ga] && !lb_post_o[ga])
         else $error("pre-recovery loopback path wrong");
      AST_POST_TAP: assert property (lb_post_o[ga] |->
                                     post_tap_only_o[ga] && !cdr_bypass_o[ga])
         else $error("post-recovery loopback taps wrong");
      AST_DIV_ONEHOT: assert property ($onehot(clk_div_o[ga]))
         else $error("divider factor not one of 1, 2, 4, 8");
   end
endmodule
`default_nettype wire

// File: tlc_mgmt_model.sv
// User-logic master on the plain register port of the controller.
// Assumes the bench calls its tasks; strobes move only after rising edges.
`timescale 1ns/100ps
`default_nettype none
module tlc_mgmt_model (
   input  wire logic                       clk_i,
   output logic      [tlc_pkg::ADDR_W-1:0] addr_o,
   output logic      [tlc_pkg::DATA_W-1:0] wdata_o,
   output logic                            wr_o,
   output logic                            rd_o,
   input  wire logic [tlc_pkg::DATA_W-1:0] rdata_i
);
   // Idle port from time zero
   initial begin
      addr_o  = 4'h0;
      wdata_o = 32'h0;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
   end
   // One-cycle write; apart from a reset, settings change only through this port
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge clk_i);
      wr_o    <= 1'b0;
   endtask
   // Read data lives only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge clk_i);
      rd_o   <= 1'b0;
      #1;
      d = rdata_i;
   endtask
endmodule
`default_nettype wire

// File: tlc_reconfig_ctrl_tb_top.sv
// Self-checking bench for the reconfiguration controller, four channels.
// Assumes a 50 MHz clock and a short calibration count for simulation.
`timescale 1ns/100ps
`default_nettype none
module tlc_reconfig_ctrl_tb_top;
   logic                 clk_i, rst_i, por_rst_i, wr, rd, busy;
   logic [3:0]           addr;
   logic [31:0]          wdata, rdata, v;
   logic [3:0]           lbpre, lbpost, byp, txen, ptap, rxen;
   logic [3:0][5:0]      swing;
   logic [3:0][4:0]      pre;
   logic [3:0][2:0]      eq;
   logic [3:0][1:0]      gain;
   logic [3:0][3:0]      div;
   logic [3:0][0:0]      pll;
   int                   mismatches, tests_run, n;
   // Master model and device under test
   tlc_mgmt_model u_m (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
      .rdata_i(rdata));
   tlc_reconfig_ctrl #(.NUM_CH(4), .NUM_PLL(2), .OP_CYCLES(10), .CAL_CYCLES(4)) u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .por_rst_i(por_rst_i), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .busy_o(busy), .lb_pre_o(lbpre),
      .lb_post_o(lbpost), .cdr_bypass_o(byp), .tx_stages_en_o(txen), .post_tap_only_o(ptap),
      .rx_fabric_en_o(rxen), .diff_swing_o(swing), .preemph_o(pre), .rx_eq_o(eq),
      .dc_gain_o(gain), .clk_div_o(div), .pll_sel_o(pll));
   // Free-running management clock; its rate is a house choice
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Bounded wait for busy low; counts edges waited
   task automatic idle();
      n = 0;
      while (busy !== 1'b0 && n < 300) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      chk(busy, 32'h0);
   endtask
   // Write then wait: op returns once busy is low, or after at most 300 edges
   task automatic op(input logic [3:0] a, input logic [31:0] d);
      u_m.wr(a, d);
      #1;
      idle();
   endtask
   task automatic t_cal();
      #1;
      chk(busy, 1);
      idle();
      u_m.rd(tlc_pkg::REG_STATUS, v);
      chk(v, 32'h2);
   endtask
   task automatic t_swing();
      u_m.wr(tlc_pkg::REG_CH_SEL, 32'h1);
      u_m.wr(tlc_pkg::REG_DIFF_SWING, 32'h2A);
      #1;
      chk(busy, 1);
      idle();
      chk(n, 10);
      chk(swing[1], 6'h2A);
      chk(swing[0], 6'h10);
      u_m.wr(tlc_pkg::REG_RX_EQ, 32'h5);
      op(tlc_pkg::REG_PREEMPH, 32'h7);
      chk({eq[1], pre[1]}, 8'hA0);
      u_m.rd(tlc_pkg::REG_STATUS, v);
      chk(v, 32'h6);
      u_m.wr(tlc_pkg::REG_STATUS, 32'h4);
      op(tlc_pkg::REG_DC_GAIN, 32'h3);
      chk(gain[1], 2'h3);
   endtask
   task automatic t_loop();
      op(tlc_pkg::REG_LOOPBACK, 32'h1);
      chk({lbpre, byp}, 8'h22);
      chk({txen, rxen}, 8'hDF);
      op(tlc_pkg::REG_PREEMPH, 32'h3);
      chk(pre[1], 5'h0);
      u_m.rd(tlc_pkg::REG_STATUS, v);
      chk(v, 32'h6);
      u_m.wr(tlc_pkg::REG_STATUS, 32'h4);
      op(tlc_pkg::REG_LOOPBACK, 32'h2);
      chk({lbpost, ptap, lbpre, txen}, 16'h220F);
      op(tlc_pkg::REG_PREEMPH, 32'h3);
      chk(pre[1], 5'h3);
      op(tlc_pkg::REG_LOOPBACK, 32'h0);
      chk({lbpre, lbpost}, 8'h00);
      op(tlc_pkg::REG_LOOPBACK, 32'h1);
      op(tlc_pkg::REG_LOOPBACK, 32'h3);
      chk({lbpre, lbpost, byp, txen}, 16'h000F);
      u_m.rd(tlc_pkg::REG_LOOPBACK, v);
      chk(v, 32'h0);
      @(posedge clk_i);
      #1;
      chk(rdata, 32'h0);
   endtask
   task automatic t_div();
      for (int c = 0; c < 4; c++) begin
         op(tlc_pkg::REG_CLK_DIV, c);
         chk(div[1], 4'h1 << c);
      end
      op(tlc_pkg::REG_PLL_SEL, 32'h1);
      chk(pll[1], 1'b1);
      u_m.rd(tlc_pkg::REG_CLK_DIV, v);
      chk(v, 32'h3);
      op(tlc_pkg::REG_PLL_SEL, 32'h2);
      chk(pll[1], 1'b1);
      u_m.wr(tlc_pkg::REG_CH_SEL, 32'h4);
      u_m.rd(tlc_pkg::REG_STATUS, v);
      chk(v, 32'h6);
      u_m.rd(tlc_pkg::REG_CH_SEL, v);
      chk(v, 32'h1);
   endtask
   // Controller reset alone in user mode
   task automatic t_rst();
      @(posedge clk_i);
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      idle();
      chk(n <= 2, 1);
      chk(swing[1], 6'h10);
      u_m.rd(tlc_pkg::REG_STATUS, v);
      chk(v, 32'h2);
   endtask
   task automatic end_sim();
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Main sequence: both resets for four cycles, then the scenarios
   initial begin
      rst_i = 1'b1;
      por_rst_i = 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      por_rst_i <= 1'b0;
      t_cal();
      t_swing();
      t_loop();
      t_div();
      t_rst();
      end_sim();
   end
   // Watchdog, about twenty times the expected run
   initial begin
      #100000;
      mismatches++;
      end_sim();
   end
endmodule
`default_nettype wire
